/* File: fbdsc_drive.sv */
`timescale 1ns/10ps
`default_nettype none
module fbdsc_drive
    import fbdsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // link
    fbdsc_if.drive           link,
    // selector switch pins
    input  wire logic [3:0]  stn_tens_i,
    input  wire logic [3:0]  stn_units_i,
    input  wire logic [2:0]  speed_sel_i,
    // mode parameter and panel selection
    input  wire logic [1:0]  operation_mode_param_i,
    input  wire logic        panel_operation_i,
    // drive core state
    input  wire logic        fwd_running_i,
    input  wire logic        rev_running_i,
    input  wire logic        up_to_freq_i,
    input  wire logic        overload_i,
    input  wire logic        freq_detect_i,
    input  wire logic        alarm_i,
    input  wire logic [15:0] out_freq_i,
    input  wire logic [15:0] out_curr_i,
    input  wire logic [15:0] out_volt_i,
    input  wire logic [15:0] alarm_def_i,
    input  wire logic [15:0] special_mon_i,
    input  wire logic        link_fault_i,
    // function assignment parameters
    input  wire logic [2:0]  out_func_sel_i [3],
    input  wire logic [2:0]  in_func_sel_i [4],
    // outputs to the drive core
    output fbdsc_cmd_t       core_cmd_o,
    output logic [15:0]      vol_freq_o,
    output logic [15:0]      nv_freq_o,
    output logic             nv_write_o,
    output logic             param_write_o,
    output logic [7:0]       param_code_o,
    output logic [15:0]      param_wdata_o,
    output logic             core_reset_o,
    output logic [6:0]       station_o,
    output fbdsc_speed_t     speed_o,
    output logic             link_err_led_o,
    output logic             net_mode_o
);
    // flag source selection over the raw status flags
    function automatic logic pick_flag(input logic [2:0] sel, input fbdsc_status_t f);
        logic [6:0] v;
        v = f;
        pick_flag = (sel < 3'h7) ? v[sel] : 1'b0;
    endfunction

    // all drive state
    typedef struct packed {
        logic [1:0]    sync_pins1;  // unused pair slot kept zero
        logic [10:0]   sw_s1;       // first sync stage of switches
        logic [10:0]   sw_s2;       // second sync stage
        logic [1:0]    boot;        // start-up counter after reset release, stops at 3
        logic [6:0]    station;
        logic [2:0]    speed;
        logic          cfg_err;
        logic          net_mode;
        fbdsc_cmd_t    cmd;
        logic [15:0]   mon_word;
        logic          mon_vld;
        logic [15:0]   vol_freq;
        logic [15:0]   nv_freq;
        logic          nv_wr;
        logic          vol_done;
        logic          nv_done;
        logic          ack;
        logic          werr;
        logic [15:0]   rdata;
        logic          pw;
        logic          crst;
        fbdsc_status_t status;
    } fbdsc_drv_t;

    fbdsc_drv_t    s_q;
    fbdsc_drv_t    s_d;
    fbdsc_status_t raw;
    logic [6:0]    stn_num;
    logic          running;
    logic [5:0]    cmd_raw;
    logic [5:0]    cmd_map;

    // raw flags and station arithmetic from synced switches
    always_comb begin
        running = fwd_running_i | rev_running_i;
        raw = '{fwd_running_i, rev_running_i, running, up_to_freq_i,
                overload_i, freq_detect_i, alarm_i};
        stn_num = 7'(s_q.sw_s2[10:7] * FBDSC_TENS_WEIGHT) + 7'(s_q.sw_s2[6:3]);
        cmd_raw = link.cmd;
        cmd_map = cmd_raw;
        // low, mid, high speed and halt may be reassigned to other slots
        for (int i = 0; i < 4; i++) begin
            cmd_map[3 - i] = (in_func_sel_i[i] < 3'h6) ? cmd_raw[in_func_sel_i[i]] : 1'b0;
        end
    end

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.sync_pins1 = '0;
        s_d.sw_s1 = {stn_tens_i, stn_units_i, speed_sel_i};
        s_d.sw_s2 = s_q.sw_s1;
        s_d.ack = 1'b0;
        s_d.werr = 1'b0;
        s_d.pw = 1'b0;
        s_d.crst = 1'b0;
        s_d.nv_wr = 1'b0;
        // capture selectors once, after synchroniser fills
        if (s_q.boot != 2'h3) begin
            s_d.boot = s_q.boot + 2'h1;
            if (s_q.boot == 2'h2) begin
                // out-of-range digits or number leave station at zero
                if (s_q.sw_s2[10:7] <= FBDSC_DIGIT_MAX && s_q.sw_s2[6:3] <= FBDSC_DIGIT_MAX
                    && stn_num >= FBDSC_STN_MIN && stn_num <= FBDSC_STN_MAX) begin
                    s_d.station = stn_num;
                end
                s_d.speed = s_q.sw_s2[2:0];
                s_d.cfg_err = s_q.sw_s2[2:0] >= FBDSC_SPD_FIRST_BAD
                              || !(stn_num >= FBDSC_STN_MIN && stn_num <= FBDSC_STN_MAX);
                // mode 0 starts in network mode, 1 panel, 2 network
                s_d.net_mode = (operation_mode_param_i != FBDSC_MODE_PANEL);
            end
        end else begin
            // in switchable mode the panel may change mode while stopped
            if (operation_mode_param_i == FBDSC_MODE_SWITCH) begin
                if (!running) begin
                    s_d.net_mode = !panel_operation_i;
                end
            end else begin
                s_d.net_mode = (operation_mode_param_i == FBDSC_MODE_NET);
            end
        end
        // status flags always refreshed, three outputs reassignable
        s_d.status = raw;
        s_d.status.running = pick_flag(out_func_sel_i[0], raw);
        s_d.status.freq_detect_flag = pick_flag(out_func_sel_i[1], raw);
        s_d.status.alarm = pick_flag(out_func_sel_i[2], raw);
        // run commands only from network mode
        s_d.cmd = (s_q.net_mode && !s_q.cfg_err) ? fbdsc_cmd_t'(cmd_map) : '0;
        // monitor word tracks selected item while requested
        if (link.monitor_request && s_q.boot == 2'h3) begin
            s_d.mon_vld = 1'b1;
            case (link.monitor_code)
                FBDSC_MON_FREQ: s_d.mon_word = out_freq_i;
                FBDSC_MON_CURR: s_d.mon_word = out_curr_i;
                FBDSC_MON_VOLT: s_d.mon_word = out_volt_i;
                FBDSC_MON_ALARM: s_d.mon_word = alarm_def_i;
                FBDSC_MON_SPECIAL: s_d.mon_word = special_mon_i;
                default: s_d.mon_word = '0;
            endcase
        end else begin
            s_d.mon_vld = 1'b0;
        end
        // frequency writes: done bit follows request level in network mode
        if (link.volatile_freq_write_req && s_q.net_mode) begin
            if (!s_q.vol_done) begin
                s_d.vol_freq = link.set_freq_word;
            end
            s_d.vol_done = 1'b1;
        end else begin
            s_d.vol_done = 1'b0;
        end
        if (link.nv_freq_write_req && s_q.net_mode) begin
            if (!s_q.nv_done) begin
                s_d.nv_freq = link.set_freq_word;
                s_d.nv_wr = 1'b1;
            end
            s_d.nv_done = 1'b1;
        end else begin
            s_d.nv_done = 1'b0;
        end
        // parameter access
        if (link.param_write_req) begin
            s_d.ack = 1'b1;
            if (!s_q.net_mode || running) begin
                s_d.werr = 1'b1;
            end else begin
                s_d.pw = 1'b1;
            end
        end else if (link.param_read_req) begin
            s_d.ack = 1'b1;
            s_d.rdata = link.param_code == FBDSC_MON_SPECIAL ? special_mon_i : alarm_def_i;
        end
        // network reset
        if (link.net_reset_req && s_q.net_mode && !link_fault_i) begin
            s_d.crst = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.net_mode <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // link outputs
    assign link.status             = s_q.status;
    assign link.monitor_valid      = s_q.mon_vld;
    assign link.monitor_value_word = s_q.mon_word;
    assign link.volatile_freq_done = s_q.vol_done;
    assign link.nv_freq_done       = s_q.nv_done;
    assign link.param_ack          = s_q.ack;
    assign link.param_write_err    = s_q.werr;
    assign link.param_rdata        = s_q.rdata;
    assign link.comm_error         = s_q.cfg_err | link_fault_i;
    // core outputs
    assign core_cmd_o     = s_q.cmd;
    assign vol_freq_o     = s_q.vol_freq;
    assign nv_freq_o      = s_q.nv_freq;
    assign nv_write_o     = s_q.nv_wr;
    assign param_write_o  = s_q.pw;
    assign param_code_o   = link.param_code;
    assign param_wdata_o  = link.param_wdata;
    assign core_reset_o   = s_q.crst;
    assign station_o      = s_q.station;
    assign speed_o        = fbdsc_speed_t'(s_q.speed);
    assign link_err_led_o = s_q.cfg_err;
    assign net_mode_o     = s_q.net_mode;
endmodule
`default_nettype wire

/* File: fbdsc_pkg.sv */
`default_nettype none
package fbdsc_pkg;
    // station and speed selector limits
    localparam logic [6:0] FBDSC_STN_MIN     = 7'h01;
    localparam logic [6:0] FBDSC_STN_MAX     = 7'h40;
    localparam logic [3:0] FBDSC_DIGIT_MAX   = 4'h9;
    localparam logic [6:0] FBDSC_TENS_WEIGHT = 7'h0a;
    localparam logic [2:0] FBDSC_SPD_FIRST_BAD = 3'h5;
    // operation mode parameter values
    localparam logic [1:0] FBDSC_MODE_SWITCH = 2'h0;
    localparam logic [1:0] FBDSC_MODE_PANEL  = 2'h1;
    localparam logic [1:0] FBDSC_MODE_NET    = 2'h2;
    localparam logic [1:0] FBDSC_MODE_RESET  = FBDSC_MODE_NET;
    // monitor select codes
    localparam logic [7:0] FBDSC_MON_FREQ    = 8'h01;
    localparam logic [7:0] FBDSC_MON_CURR    = 8'h02;
    localparam logic [7:0] FBDSC_MON_VOLT    = 8'h03;
    localparam logic [7:0] FBDSC_MON_ALARM   = 8'h04;
    localparam logic [7:0] FBDSC_MON_SPECIAL = 8'hf3;
    // refresh cycle bounds in microseconds and in cycles at 100 MHz
    localparam int FBDSC_CLK_MHZ        = 100;
    localparam int FBDSC_REFRESH_MIN_US = 1100;
    localparam int FBDSC_REFRESH_MAX_US = 141000;
    localparam int FBDSC_REFRESH_MIN_CYC = FBDSC_REFRESH_MIN_US * FBDSC_CLK_MHZ;
    localparam int FBDSC_REFRESH_MAX_CYC = FBDSC_REFRESH_MAX_US * FBDSC_CLK_MHZ;
    // transmission speed codes
    typedef enum logic [2:0] {
        FBDSC_SPD_156K = 3'h0,
        FBDSC_SPD_625K = 3'h1,
        FBDSC_SPD_2M5  = 3'h2,
        FBDSC_SPD_5M   = 3'h3,
        FBDSC_SPD_10M  = 3'h4
    } fbdsc_speed_t;
    // status flag bundle
    typedef struct packed {
        logic fwd_running;
        logic rev_running;
        logic running;
        logic up_to_freq_flag;
        logic overload_flag;
        logic freq_detect_flag;
        logic alarm;
    } fbdsc_status_t;
    // command bundle
    typedef struct packed {
        logic forward_run_cmd;
        logic reverse_run_cmd;
        logic low_speed_sel;
        logic mid_speed_sel;
        logic high_speed_sel;
        logic output_halt;
    } fbdsc_cmd_t;
endpackage
`default_nettype wire

/* File: fbdsc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface fbdsc_if;
    import fbdsc_pkg::*;
    // master to drive, one link refresh worth of signals
    logic          refresh;                 // one-cycle refresh strobe
    fbdsc_cmd_t    cmd;                     // run and speed selects
    logic          monitor_request;         // keep monitor word updated
    logic [7:0]    monitor_code;            // selected monitor item
    logic          volatile_freq_write_req; // write set frequency to volatile store
    logic          nv_freq_write_req;       // write set frequency to nonvolatile store
    logic [15:0]   set_freq_word;           // 0.01 Hz steps
    logic          param_write_req;         // one-cycle pulse
    logic          param_read_req;          // one-cycle pulse
    logic          net_reset_req;           // one-cycle pulse
    logic [7:0]    param_code;
    logic [15:0]   param_wdata;
    // drive to master
    fbdsc_status_t status;
    logic          monitor_valid;
    logic [15:0]   monitor_value_word;
    logic          volatile_freq_done;
    logic          nv_freq_done;
    logic          param_ack;               // one-cycle pulse
    logic          param_write_err;         // with param_ack
    logic [15:0]   param_rdata;
    logic          comm_error;

    modport drive (
        input  refresh, cmd, monitor_request, monitor_code, volatile_freq_write_req,
               nv_freq_write_req, set_freq_word, param_write_req, param_read_req,
               net_reset_req, param_code, param_wdata,
        output status, monitor_valid, monitor_value_word, volatile_freq_done,
               nv_freq_done, param_ack, param_write_err, param_rdata, comm_error
    );
    modport master (
        output refresh, cmd, monitor_request, monitor_code, volatile_freq_write_req,
               nv_freq_write_req, set_freq_word, param_write_req, param_read_req,
               net_reset_req, param_code, param_wdata,
        input  status, monitor_valid, monitor_value_word, volatile_freq_done,
               nv_freq_done, param_ack, param_write_err, param_rdata, comm_error
    );
endinterface
`default_nettype wire

/* File: fbdsc_master.sv */
`timescale 1ns/10ps
`default_nettype none
// master end: holds run, monitor and frequency requests level, pulses parameter and reset requests, and issues a refresh strobe each interval
module fbdsc_master
    import fbdsc_pkg::*;
#(
    parameter int REFRESH_CYC = FBDSC_REFRESH_MIN_CYC
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // link
    fbdsc_if.master         link,
    // user side
    input  wire fbdsc_cmd_t cmd_i,
    input  wire logic       monitor_request_i,
    input  wire logic [7:0] monitor_code_i,
    input  wire logic       vol_write_i,
    input  wire logic       nv_write_i,
    input  wire logic [15:0] set_freq_i,
    input  wire logic       param_write_i,
    input  wire logic       param_read_i,
    input  wire logic       net_reset_i,
    input  wire logic [7:0] param_code_i,
    input  wire logic [15:0] param_wdata_i,
    output logic [15:0]     monitor_value_o,
    output logic            monitor_valid_o,
    output fbdsc_status_t   status_o,
    output logic            param_ack_o,
    output logic            param_write_err_o,
    output logic [15:0]     param_rdata_o,
    output logic            comm_error_o
);
    // all master state
    typedef struct packed {
        logic [23:0]   cnt;
        logic          refresh;
        fbdsc_cmd_t    cmd;
        logic          mon_req;
        logic [7:0]    mon_code;
        logic          vol_req;
        logic          nv_req;
        logic [15:0]   freq;
        logic          pw;
        logic          pr;
        logic          rst;
        logic [7:0]    pcode;
        logic [15:0]   pwdata;
        logic [15:0]   mon_val;
        logic          mon_vld;
        fbdsc_status_t status;
        logic          ack;
        logic          werr;
        logic [15:0]   rdata;
        logic          cerr;
    } fbdsc_mst_t;

    fbdsc_mst_t s_q;
    fbdsc_mst_t s_d;

    // refresh timer and latching of requests into link words
    always_comb begin
        s_d = s_q;
        s_d.refresh = 1'b0;
        s_d.pw = 1'b0;
        s_d.pr = 1'b0;
        s_d.rst = 1'b0;
        s_d.ack = link.param_ack;
        s_d.werr = link.param_write_err;
        if (link.param_ack) begin
            s_d.rdata = link.param_rdata;
        end
        // cyclic refresh runs continuously once out of reset
        if (s_q.cnt >= 24'(REFRESH_CYC - 1)) begin
            s_d.cnt = '0;
            s_d.refresh = 1'b1;
            s_d.cmd = cmd_i;
            s_d.mon_req = monitor_request_i;
            s_d.mon_code = monitor_code_i;
            // volatile store preferred for changing values, user picks
            s_d.vol_req = vol_write_i;
            s_d.nv_req = nv_write_i;
            s_d.freq = set_freq_i;
            s_d.pw = param_write_i;
            s_d.pr = param_read_i;
            s_d.rst = net_reset_i;
            s_d.pcode = param_code_i;
            s_d.pwdata = param_wdata_i;
            s_d.mon_val = link.monitor_value_word;
            s_d.mon_vld = link.monitor_valid;
            s_d.status = link.status;
            s_d.cerr = link.comm_error;
        end else begin
            s_d.cnt = s_q.cnt + 24'h000001;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // link drive
    assign link.refresh                 = s_q.refresh;
    assign link.cmd                     = s_q.cmd;
    assign link.monitor_request         = s_q.mon_req;
    assign link.monitor_code            = s_q.mon_code;
    assign link.volatile_freq_write_req = s_q.vol_req;
    assign link.nv_freq_write_req       = s_q.nv_req;
    assign link.set_freq_word           = s_q.freq;
    assign link.param_write_req         = s_q.pw;
    assign link.param_read_req          = s_q.pr;
    assign link.net_reset_req           = s_q.rst;
    assign link.param_code              = s_q.pcode;
    assign link.param_wdata             = s_q.pwdata;
    // user outputs
    assign monitor_value_o   = s_q.mon_val;
    assign monitor_valid_o   = s_q.mon_vld;
    assign status_o          = s_q.status;
    assign param_ack_o       = s_q.ack;
    assign param_write_err_o = s_q.werr;
    assign param_rdata_o     = s_q.rdata;
    assign comm_error_o      = s_q.cerr;
endmodule
`default_nettype wire

/* File: fbdsc_checker_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// watches the link between master and drive for handshake timing
module fbdsc_checker
    import fbdsc_pkg::*;
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    // link signals
    input  wire logic          monitor_request,
    input  wire logic          monitor_valid,
    input  wire logic          volatile_freq_write_req,
    input  wire logic          volatile_freq_done,
    input  wire logic          nv_freq_write_req,
    input  wire logic          nv_freq_done,
    input  wire logic          param_write_req,
    input  wire logic          param_read_req,
    input  wire logic          param_ack,
    input  wire logic          param_write_err,
    input  wire fbdsc_status_t status
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // parameter write strobe on the link
    sequence s_wr;
        param_write_req;
    endsequence
    // drive reports motor motion
    sequence s_run;
        status.fwd_running || status.rev_running;
    endsequence
    // acknowledge lasting exactly one cycle
    sequence s_ack;
        param_ack ##1 !param_ack;
    endsequence
    mon_valid_set_a: assert property (monitor_request |=> monitor_valid)
        else $error("monitor valid missing");
    mon_valid_clr_a: assert property (!monitor_request |=> !monitor_valid)
        else $error("monitor valid without request");
    vol_done_set_a: assert property (volatile_freq_write_req |=> volatile_freq_done)
        else $error("volatile write not completed");
    vol_done_clr_a: assert property (!volatile_freq_write_req |=> !volatile_freq_done)
        else $error("volatile done without request");
    nv_done_set_a: assert property (nv_freq_write_req |=> nv_freq_done)
        else $error("nonvolatile write not completed");
    ack_pulse_a: assert property ((param_write_req || param_read_req) |=> s_ack)
        else $error("parameter access not acknowledged once");
    ack_cause_a: assert property (param_ack |-> $past(param_write_req || param_read_req))
        else $error("acknowledge without access");
    busy_write_err_a: assert property (s_wr ##0 s_run |=> param_write_err)
        else $error("write while running not refused");
    werr_cause_a: assert property (param_write_err |-> param_ack && $past(param_write_req))
        else $error("write error without write");
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fbdsc_pkg::*;
    // clock, reset, tallies
    logic          clk_i = 1'b0;
    logic          sys_rst_i = 1'b1;
    int            mismatches = 0;
    int            checks_done = 0;
    int            cyc = 0;
    // master user side
    fbdsc_cmd_t    cmd = '0;
    logic          mreq = 0, volw = 0, nvw = 0, pw = 0, pr = 0, nrst = 0;
    logic [7:0]    mcode = 8'h01, pcode = 8'h0a, wcode;
    logic [15:0]   sfreq = 16'h0, pwd = 16'h0, mon_val, rdata;
    logic          mon_vld, ack, werr, cerr;
    fbdsc_status_t mstat;
    // drive core side
    logic [3:0]    tens = 4'h2, units = 4'h6;
    logic [2:0]    spd = 3'h0;
    logic [1:0]    mode = FBDSC_MODE_NET;
    logic          panel = 0, fwd_r = 0, rev_r = 0, utf = 0, ovl = 0, fdet = 0, alm = 0, lfault = 0;
    logic [15:0]   core_v [5] = '{16'h1388, 16'h02bc, 16'h0898, 16'h0007, 16'h5a5a};
    logic [7:0]    codes [5] = '{FBDSC_MON_FREQ, FBDSC_MON_CURR, FBDSC_MON_VOLT, FBDSC_MON_ALARM, FBDSC_MON_SPECIAL};
    logic [2:0]    osel [3] = '{3'h6, 3'h6, 3'h6};
    logic [2:0]    isel [4] = '{3'h3, 3'h2, 3'h1, 3'h0};
    fbdsc_cmd_t    ccmd;
    logic [15:0]   vfreq, nvfreq, pwd_o;
    logic [7:0]    pcode_o;
    logic [6:0]    stn;
    fbdsc_speed_t  spdo;
    logic          nvwr, pwr, crst, led, netm;
    // port event counts
    logic [15:0]   acks = '0, werrs = '0, wrs = '0, rsts = '0;
    // station selector table and expected numbers
    logic [7:0]    stab [4] = '{8'h01, 8'h64, 8'h65, 8'h00};
    logic [15:0]   stexp [4] = '{16'h0001, 16'h0040, 16'h0000, 16'h0000};

    always #5 clk_i = ~clk_i;

    fbdsc_if link ();
    fbdsc_master #(.REFRESH_CYC(4)) u_fbdsc_master (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link), .cmd_i(cmd), .monitor_request_i(mreq),
        .monitor_code_i(mcode), .vol_write_i(volw), .nv_write_i(nvw), .set_freq_i(sfreq),
        .param_write_i(pw), .param_read_i(pr), .net_reset_i(nrst), .param_code_i(pcode),
        .param_wdata_i(pwd), .monitor_value_o(mon_val), .monitor_valid_o(mon_vld), .status_o(mstat),
        .param_ack_o(ack), .param_write_err_o(werr), .param_rdata_o(rdata), .comm_error_o(cerr));
    fbdsc_drive u_fbdsc_drive (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(link), .stn_tens_i(tens), .stn_units_i(units),
        .speed_sel_i(spd), .operation_mode_param_i(mode), .panel_operation_i(panel),
        .fwd_running_i(fwd_r), .rev_running_i(rev_r), .up_to_freq_i(utf), .overload_i(ovl),
        .freq_detect_i(fdet), .alarm_i(alm), .out_freq_i(core_v[0]), .out_curr_i(core_v[1]),
        .out_volt_i(core_v[2]), .alarm_def_i(core_v[3]), .special_mon_i(core_v[4]),
        .link_fault_i(lfault), .out_func_sel_i(osel), .in_func_sel_i(isel), .core_cmd_o(ccmd),
        .vol_freq_o(vfreq), .nv_freq_o(nvfreq), .nv_write_o(nvwr), .param_write_o(pwr),
        .param_code_o(pcode_o), .param_wdata_o(pwd_o), .core_reset_o(crst), .station_o(stn),
        .speed_o(spdo), .link_err_led_o(led), .net_mode_o(netm));
    fbdsc_checker u_fbdsc_checker (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .monitor_request(link.monitor_request),
        .monitor_valid(link.monitor_valid), .volatile_freq_write_req(link.volatile_freq_write_req),
        .volatile_freq_done(link.volatile_freq_done), .nv_freq_write_req(link.nv_freq_write_req),
        .nv_freq_done(link.nv_freq_done), .param_write_req(link.param_write_req),
        .param_read_req(link.param_read_req), .param_ack(link.param_ack),
        .param_write_err(link.param_write_err), .status(link.status));

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // compare one value
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // wait n edges, then step off the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // reset held six cycles, then time for selector capture and refresh
    task automatic do_reset;
        sys_rst_i = 1'b1;
        w(6);
        sys_rst_i = 1'b0;
        w(16);
    endtask
    // one write, read or reset request held over one refresh; counts acks, errors, writes, resets
    task automatic op(input int k, input logic [15:0] ea, ew, ep, er);
        logic [15:0] a, b, c, d;
        a = acks;
        b = werrs;
        c = wrs;
        d = rsts;
        pw = (k == 0);
        pr = (k == 1);
        nrst = (k == 2);
        w(4);
        pw = 0;
        pr = 0;
        nrst = 0;
        w(16);
        chk("acks", acks - a, ea);
        chk("write_errs", werrs - b, ew);
        chk("core_writes", wrs - c, ep);
        chk("core_resets", rsts - d, er);
    endtask

    // event tallies and hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (ack) acks <= acks + 16'h1;
        if (ack && werr) werrs <= werrs + 16'h1;
        if (pwr) begin
            wrs <= wrs + 16'h1;
            wcode <= pcode_o;
        end
        if (crst) rsts <= rsts + 16'h1;
        if (cyc == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        do_reset;
        // station numbers at and past the limits
        for (int i = 0; i < 4; i++) begin
            {tens, units} = stab[i];
            do_reset;
            chk("station", 16'(stn), stexp[i]);
            chk("comm_error", 16'(cerr), 16'(stexp[i] == 16'h0));
        end
        // speed codes, selectors moved after start-up
        for (int c = 0; c < 8; c++) begin
            spd = 3'(c);
            {tens, units} = 8'h26;
            do_reset;
            tens = 4'h5;
            spd = 3'(c + 1);
            w(16);
            chk("station", 16'(stn), 16'h001a);
            if (c < 5) chk("speed", 16'(spdo), 16'(c));
            chk("link_led", 16'(led), 16'(c > 4));
            chk("comm_error", 16'(cerr), 16'(c > 4));
        end
        // network mode while running
        spd = 3'h0;
        tens = 4'h2;
        do_reset;
        fwd_r = 1;
        utf = 1;
        cmd.forward_run_cmd = 1;
        w(20);
        chk("status", 16'(mstat), 16'h005b);
        chk("core_fwd", 16'(ccmd.forward_run_cmd), 16'h0001);
        chk("net_mode", 16'(netm), 16'h0001);
        mreq = 1;
        for (int i = 0; i < 5; i++) begin
            mcode = codes[i];
            w(16);
            chk("mon_valid", 16'(mon_vld), 16'h0001);
            chk("mon_word", mon_val, core_v[i]);
        end
        mreq = 0;
        w(16);
        chk("mon_valid", 16'(mon_vld), 16'h0000);
        op(0, 16'h1, 16'h1, 16'h0, 16'h0);
        op(2, 16'h0, 16'h0, 16'h0, 16'h1);
        // stopped: writes and frequency stores
        fwd_r = 0;
        cmd.forward_run_cmd = 0;
        w(20);
        op(0, 16'h1, 16'h0, 16'h1, 16'h0);
        chk("param_code", 16'(wcode), 16'(pcode));
        sfreq = 16'h0bb8;
        volw = 1;
        w(16);
        chk("vol_freq", vfreq, 16'h0bb8);
        volw = 0;
        sfreq = 16'h0fa0;
        nvw = 1;
        w(16);
        chk("nv_freq", nvfreq, 16'h0fa0);
        chk("vol_freq", vfreq, 16'h0bb8);
        nvw = 0;
        lfault = 1;
        w(4);
        op(2, 16'h0, 16'h0, 16'h0, 16'h0);
        lfault = 0;
        // panel mode refuses control but serves reads
        mode = FBDSC_MODE_PANEL;
        do_reset;
        cmd.forward_run_cmd = 1;
        w(20);
        chk("core_fwd", 16'(ccmd.forward_run_cmd), 16'h0000);
        chk("net_mode", 16'(netm), 16'h0000);
        cmd.forward_run_cmd = 0;
        op(0, 16'h1, 16'h1, 16'h0, 16'h0);
        op(1, 16'h1, 16'h0, 16'h0, 16'h0);
        op(2, 16'h0, 16'h0, 16'h0, 16'h0);
        mreq = 1;
        mcode = FBDSC_MON_VOLT;
        w(16);
        chk("mon_word", mon_val, core_v[2]);
        mreq = 0;
        // switchable mode starts networked, panel selection takes over
        mode = FBDSC_MODE_SWITCH;
        do_reset;
        chk("net_mode", 16'(netm), 16'h0001);
        panel = 1;
        w(8);
        chk("net_mode", 16'(netm), 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
